// ==== rtl/led_pkg.sv ====
`default_nettype none
package led_pkg;
    // Register byte offsets
    localparam logic [11:0] CFG_OFF        = 12'h080;
    localparam logic [11:0] THR_OFF        = 12'h084;
    localparam logic [11:0] BLINK_OFF      = 12'h088;
    // Field positions in the lamp configuration word
    localparam int          ENABLE_BIT     = 0;
    localparam int          SW_CTRL_BIT    = 1;
    localparam int          LEVEL_BIT      = 2;
    localparam int          KIND_BIT       = 3;
    localparam int          TEST_BIT       = 31;
    // Upper half of the threshold and blink words
    localparam int          HI_LSB         = 16;
    // Defaults when no image has been loaded
    localparam logic        KIND_DEF       = 1'b0;
    localparam logic        LEVEL_DEF      = 1'b0;
    localparam logic        ENABLE_DEF     = 1'b1;
    localparam logic [15:0] THR_DISABLED   = 16'hffff;
    localparam logic [15:0] FAST_BLINK_DEF = 16'h0032;
    localparam logic [15:0] SLOW_BLINK_DEF = 16'h00fa;
    // Time base
    localparam int          CLK_PERIOD_NS  = 4;
    localparam int          US_NS          = 1000;
    localparam int          US_CYCLES      = (US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          MS_US          = 1000;
    // Blink selection, one-hot
    typedef enum logic [3:0] {
        MODE_OFF    = 4'b0001,
        MODE_STEADY = 4'b0010,
        MODE_SLOW   = 4'b0100,
        MODE_FAST   = 4'b1000
    } mode_type;
endpackage : led_pkg
`default_nettype wire

// ==== rtl/activity_led_control.sv ====
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module activity_led_control #(
    parameter int RATE_W = 16               // Threshold and period width
) (
    input  wire logic              pclk,           // 250 MHz clock
    input  wire logic              presetn,        // Async reset, low
    input  wire logic              psel,           // APB select
    input  wire logic              penable,        // APB access phase
    input  wire logic              pwrite,         // APB direction
    input  wire logic [11:0]       paddr,          // APB byte address
    input  wire logic [31:0]       pwdata,         // APB write data
    input  wire logic [3:0]        pstrb,          // APB byte strobes
    output logic                   pready,         // APB ready
    output logic [31:0]            prdata,         // APB read data
    output logic                   pslverr,        // APB error
    input  wire logic              eeprom_load,    // Image load pulse
    input  wire logic              eeprom_drive_kind_flag,       // Image kind
    input  wire logic              eeprom_active_level_flag,     // Image level
    input  wire logic              eeprom_indicator_enable_flag, // Image enable
    input  wire logic              usb_reset,      // USB reset pulse
    input  wire logic              lite_reset,     // Lite reset pulse
    input  wire logic              reset_protect,  // Keep protected bits
    input  wire logic [RATE_W-1:0] traffic_rate,   // Rate, 64 B/ms units
    output logic                   led_out,        // LED pin output
    output logic                   led_oe          // LED pin enable
);
    // Byte-lane merge of a write into a word
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] st);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (st[i]) begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    logic              test_q, test_d;
    logic              kind_q, kind_d;
    logic              level_q, level_d;
    logic              sw_q, sw_d;
    logic              en_q, en_d;
    logic              img_kind_q, img_kind_d;
    logic              img_level_q, img_level_d;
    logic              img_en_q, img_en_d;
    logic [RATE_W-1:0] fast_rate_threshold_q, fast_rate_threshold_d;
    logic [RATE_W-1:0] slow_rate_threshold_q, slow_rate_threshold_d;
    logic [RATE_W-1:0] fast_per_q, fast_per_d;
    logic [RATE_W-1:0] slow_per_q, slow_per_d;
    logic [31:0]       prdata_d;
    logic              pslverr_d;
    logic [31:0]       cfg_word, thr_word, blink_word;
    logic              wr_acc, setup;
    logic              link_reset;

    // Bus phases
    assign setup  = psel && !penable;
    assign wr_acc = psel && penable && pwrite;
    assign pready = psel && penable;
    assign link_reset = usb_reset || lite_reset;

    // Register images as seen on the bus
    always_comb begin
        cfg_word = 32'h0000_0000;
        cfg_word[led_pkg::TEST_BIT]    = test_q;
        cfg_word[led_pkg::KIND_BIT]    = kind_q;
        cfg_word[led_pkg::LEVEL_BIT]   = level_q;
        cfg_word[led_pkg::SW_CTRL_BIT] = sw_q;
        cfg_word[led_pkg::ENABLE_BIT]  = en_q;
        thr_word   = 32'h0000_0000;
        thr_word[led_pkg::HI_LSB +: RATE_W] = fast_rate_threshold_q;
        thr_word[RATE_W-1:0]                = slow_rate_threshold_q;
        blink_word = 32'h0000_0000;
        blink_word[led_pkg::HI_LSB +: RATE_W] = fast_per_q;
        blink_word[RATE_W-1:0]                = slow_per_q;
    end

    // Read data and error captured in the setup cycle
    always_comb begin
        prdata_d  = prdata;
        pslverr_d = pslverr;
        if (setup) begin
            prdata_d  = 32'h0000_0000;
            pslverr_d = 1'b0;
            if (paddr == led_pkg::CFG_OFF) begin
                prdata_d = cfg_word;
            end else if (paddr == led_pkg::THR_OFF) begin
                prdata_d = thr_word;
            end else if (paddr == led_pkg::BLINK_OFF) begin
                prdata_d = blink_word;
            end else begin
                pslverr_d = 1'b1;
            end
            if (pwrite || pslverr_d) begin
                prdata_d = 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            prdata  <= prdata_d;
            pslverr <= pslverr_d;
        end
    end

    // Configuration: link reset over image load over bus write
    always_comb begin
        logic [31:0] w;
        w           = merge(cfg_word, pwdata, pstrb);
        test_d      = test_q;
        kind_d      = kind_q;
        level_d     = level_q;
        sw_d        = sw_q;
        en_d        = en_q;
        img_kind_d  = img_kind_q;
        img_level_d = img_level_q;
        img_en_d    = img_en_q;
        fast_rate_threshold_d  = fast_rate_threshold_q;
        slow_rate_threshold_d  = slow_rate_threshold_q;
        fast_per_d  = fast_per_q;
        slow_per_d  = slow_per_q;
        if (wr_acc && paddr == led_pkg::CFG_OFF) begin
            test_d  = w[led_pkg::TEST_BIT];
            kind_d  = w[led_pkg::KIND_BIT];
            level_d = w[led_pkg::LEVEL_BIT];
            sw_d    = w[led_pkg::SW_CTRL_BIT];
            en_d    = w[led_pkg::ENABLE_BIT];
        end else if (wr_acc && paddr == led_pkg::THR_OFF) begin
            w          = merge(thr_word, pwdata, pstrb);
            fast_rate_threshold_d = w[led_pkg::HI_LSB +: RATE_W];
            slow_rate_threshold_d = w[RATE_W-1:0];
        end else if (wr_acc && paddr == led_pkg::BLINK_OFF) begin
            w          = merge(blink_word, pwdata, pstrb);
            fast_per_d = w[led_pkg::HI_LSB +: RATE_W];
            slow_per_d = w[RATE_W-1:0];
        end
        if (eeprom_load) begin
            img_kind_d  = eeprom_drive_kind_flag;
            img_level_d = eeprom_active_level_flag;
            img_en_d    = eeprom_indicator_enable_flag;
            kind_d      = eeprom_drive_kind_flag;
            level_d     = eeprom_active_level_flag;
            en_d        = eeprom_indicator_enable_flag;
        end
        if (link_reset && !reset_protect) begin
            kind_d  = img_kind_q;
            level_d = img_level_q;
            en_d    = img_en_q;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            test_q      <= 1'b0;
            sw_q        <= 1'b0;
            kind_q      <= led_pkg::KIND_DEF;
            level_q     <= led_pkg::LEVEL_DEF;
            en_q        <= led_pkg::ENABLE_DEF;
            img_kind_q  <= led_pkg::KIND_DEF;
            img_level_q <= led_pkg::LEVEL_DEF;
            img_en_q    <= led_pkg::ENABLE_DEF;
            fast_rate_threshold_q  <= led_pkg::THR_DISABLED[RATE_W-1:0];
            slow_rate_threshold_q  <= led_pkg::THR_DISABLED[RATE_W-1:0];
            fast_per_q  <= led_pkg::FAST_BLINK_DEF[RATE_W-1:0];
            slow_per_q  <= led_pkg::SLOW_BLINK_DEF[RATE_W-1:0];
        end else begin
            test_q      <= test_d;
            sw_q        <= sw_d;
            kind_q      <= kind_d;
            level_q     <= level_d;
            en_q        <= en_d;
            img_kind_q  <= img_kind_d;
            img_level_q <= img_level_d;
            img_en_q    <= img_en_d;
            fast_rate_threshold_q  <= fast_rate_threshold_d;
            slow_rate_threshold_q  <= slow_rate_threshold_d;
            fast_per_q  <= fast_per_d;
            slow_per_q  <= slow_per_d;
        end
    end

    localparam logic [7:0] US_LAST = 8'(led_pkg::US_CYCLES - 1);
    localparam logic [9:0] MS_LAST = 10'(led_pkg::MS_US - 1);
    logic [7:0]        us_cnt_q, us_cnt_d;
    logic [9:0]        ms_cnt_q, ms_cnt_d;
    logic [RATE_W-1:0] per_cnt_q, per_cnt_d;
    logic              phase_q, phase_d;
    logic              out_q, out_d, oe_q, oe_d;
    led_pkg::mode_type mode_q, mode_d;
    logic              us_tick, ms_tick, base_tick, lit;
    logic [RATE_W-1:0] period;

    assign us_tick = (us_cnt_q == US_LAST);
    assign ms_tick = us_tick && (ms_cnt_q == MS_LAST);
    // test bit selects 1 us base
    assign base_tick = test_q ? us_tick : ms_tick;
    assign period    = (mode_q == led_pkg::MODE_FAST) ? fast_per_q : slow_per_q;

    // Blink mode, time base and pin drive
    always_comb begin
        us_cnt_d  = us_tick ? 8'h00 : us_cnt_q + 8'h01;
        ms_cnt_d  = ms_cnt_q;
        if (us_tick) begin
            ms_cnt_d = (ms_cnt_q == MS_LAST) ? 10'h000 : ms_cnt_q + 10'h001;
        end
        if (!en_q) begin
            mode_d = led_pkg::MODE_OFF;
        end else if (sw_q) begin
            mode_d = led_pkg::MODE_SLOW;
        end else if (fast_rate_threshold_q != led_pkg::THR_DISABLED[RATE_W-1:0] && traffic_rate > fast_rate_threshold_q) begin
            mode_d = led_pkg::MODE_FAST;
        end else if (slow_rate_threshold_q != led_pkg::THR_DISABLED[RATE_W-1:0] && traffic_rate > slow_rate_threshold_q) begin
            mode_d = led_pkg::MODE_SLOW;
        end else begin
            mode_d = led_pkg::MODE_STEADY;
        end
        // Half-period counter restarts on mode change
        per_cnt_d = per_cnt_q;
        phase_d   = phase_q;
        if (mode_d != mode_q || mode_q == led_pkg::MODE_OFF || mode_q == led_pkg::MODE_STEADY) begin
            per_cnt_d = '0;
            phase_d   = 1'b1;
        end else if (base_tick) begin
            if (per_cnt_q >= period) begin
                per_cnt_d = '0;
                phase_d   = !phase_q;
            end else begin
                per_cnt_d = per_cnt_q + RATE_W'(1);
            end
        end
        lit = (mode_q == led_pkg::MODE_STEADY) || ((mode_q != led_pkg::MODE_OFF) && phase_q);
        if (kind_q) begin
            out_d = level_q ? lit : !lit;
            oe_d  = 1'b1;
        end else begin
            out_d = 1'b0;
            oe_d  = en_q && (level_q ? lit : !lit) == 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            us_cnt_q  <= 8'h00;
            ms_cnt_q  <= 10'h000;
            per_cnt_q <= '0;
            phase_q   <= 1'b1;
            mode_q    <= led_pkg::MODE_OFF;
            out_q     <= 1'b0;
            oe_q      <= 1'b0;
        end else begin
            us_cnt_q  <= us_cnt_d;
            ms_cnt_q  <= ms_cnt_d;
            per_cnt_q <= per_cnt_d;
            phase_q   <= phase_d;
            mode_q    <= mode_d;
            out_q     <= out_d;
            oe_q      <= oe_d;
        end
    end

    assign led_out = out_q;
    assign led_oe  = oe_q;

    // First cycle after reset release
    logic first_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            first_q <= 1'b1;
        end else begin
            first_q <= 1'b0;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    chk_enable_gate: assert property (!en_q |-> mode_d == led_pkg::MODE_OFF)
        else $error("disabled LED not off");
    chk_sw_slow: assert property (en_q && sw_q |=> mode_q == led_pkg::MODE_SLOW)
        else $error("software blink not slow");
    chk_sw_bypass: assert property (en_q && sw_q && traffic_rate > fast_rate_threshold_q |-> mode_d != led_pkg::MODE_FAST)
        else $error("traffic rate used under software control");
    chk_test_base: assert property (test_q && us_tick |-> base_tick)
        else $error("test base not 1 us");
    chk_ms_base: assert property (!test_q && base_tick |-> ms_cnt_q == MS_LAST && us_tick)
        else $error("normal base not 1 ms");
    chk_us_spacing: assert property (us_tick |=> !us_tick [*8])
        else $error("us tick too frequent");
    chk_od_sink: assert property (!kind_q |=> !led_out)
        else $error("open drain drove high");
    chk_pp_drive: assert property (kind_q |=> led_oe)
        else $error("push pull released pin");
    chk_level_steady: assert property (kind_q && mode_q == led_pkg::MODE_STEADY |=> led_out == $past(level_q))
        else $error("steady level wrong polarity");
    chk_por_default: assert property (first_q |-> en_q == led_pkg::ENABLE_DEF && !kind_q && !level_q)
        else $error("reset defaults wrong");
    chk_link_restore: assert property (link_reset && !reset_protect |=> en_q == $past(img_en_q) && kind_q == $past(img_kind_q))
        else $error("link reset did not restore image");
    chk_protect_hold: assert property (link_reset && reset_protect && !eeprom_load && !wr_acc |=> $stable(en_q) && $stable(level_q))
        else $error("protected bits changed");
    chk_fast_first: assert property (en_q && !sw_q && fast_rate_threshold_q != led_pkg::THR_DISABLED && traffic_rate > fast_rate_threshold_q |-> mode_d == led_pkg::MODE_FAST)
        else $error("fast threshold not first");
    chk_both_off: assert property (en_q && !sw_q && fast_rate_threshold_q == led_pkg::THR_DISABLED && slow_rate_threshold_q == led_pkg::THR_DISABLED |-> mode_d == led_pkg::MODE_STEADY)
        else $error("disabled checks not steady");
    chk_off_pin: assert property (!en_q && !kind_q |=> !led_oe)
        else $error("disabled open drain pin not released");
endmodule : activity_led_control
`default_nettype wire

// ==== dv/led_partner.sv ====
`timescale 1ns/1ps
`default_nettype none
// Indicator lamp on the pin: lamp and resistor to the supply, so a
// released pin floats up to the supply level and the lamp is dark.
module led_partner (
    input  wire logic led_out,  // Pin value from the block
    input  wire logic led_oe,   // Pin drive enable
    output logic      led_pin   // Resolved pin level
);
    // released pin left free
    // Pin level from driver and pull-up
    assign led_pin = led_oe ? led_out : 1'b1;
endmodule : led_partner
`default_nettype wire

// ==== dv/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    typedef struct packed {
        logic [31:0] cfg;
        logic [31:0] rd;
        logic        oe;
        logic        pin;
    } row_type;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rv;
    logic        pready, pslverr, led_out, led_oe, led_pin, ev;
    logic        eeprom_load = 1'b0, ek = 1'b0, el = 1'b0, ee = 1'b0;
    logic        usb_reset = 1'b0, lite_reset = 1'b0, reset_protect = 1'b0;
    logic [15:0] traffic_rate = 16'h0000;
    logic [3:0]  pstrb = 4'hf;
    int          n_fail = 0, n_tests = 0, gn;
    // Pin patterns: disabled, push-pull, open-drain, reserved bits
    row_type     rows [9] = '{
        '{32'h00000000, 32'h00000000, 1'b0, 1'b1}, '{32'h00000008, 32'h00000008, 1'b1, 1'b1},
        '{32'h0000000c, 32'h0000000c, 1'b1, 1'b0}, '{32'h0000000d, 32'h0000000d, 1'b1, 1'b1},
        '{32'h00000009, 32'h00000009, 1'b1, 1'b0}, '{32'h00000005, 32'h00000005, 1'b0, 1'b1},
        '{32'h00000001, 32'h00000001, 1'b1, 1'b0}, '{32'h7ffffff1, 32'h00000001, 1'b1, 1'b0},
        '{32'hfffffff0, 32'h80000000, 1'b0, 1'b1}};

    // Clock, 4 ns period
    always #2 pclk = ~pclk;

    activity_led_control u_activity_led_control (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .eeprom_load(eeprom_load), .eeprom_drive_kind_flag(ek),
        .eeprom_active_level_flag(el), .eeprom_indicator_enable_flag(ee),
        .usb_reset(usb_reset), .lite_reset(lite_reset), .reset_protect(reset_protect),
        .traffic_rate(traffic_rate), .led_out(led_out), .led_oe(led_oe));

    led_partner u_led_partner (.led_out(led_out), .led_oe(led_oe), .led_pin(led_pin));

    // Compare and count
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        n_tests++;
        if (s !== e) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask : chk

    // One APB transfer, waits for pready
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int k;
        k = 0;
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && k < 100) begin
            @(posedge pclk);
            k++;
        end
        if (k >= 100) begin
            n_fail++;
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, rv, ev);
    endtask : wr

    task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0, rv, ev);
        chk(nm, rv, x);
        chk({nm, "_err"}, 32'(ev), 32'h0);
    endtask : rdc

    // Settle, then cycles between two pin changes, 5000 when none
    task automatic gap(output int n);
        logic p;
        int   k;
        repeat (3) @(posedge pclk);
        k = 0;
        p = led_pin;
        while (led_pin === p && k < 5000) begin
            @(posedge pclk);
            k++;
        end
        p = led_pin;
        n = 0;
        while (led_pin === p && n < 5000) begin
            @(posedge pclk);
            n++;
        end
    endtask : gap

    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : stop_test

    // Watchdog, about 60000 cycles
    initial begin
        #240000;
        n_fail++;
        stop_test();
    end

    // Main sequence
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        chk("pin_rst", {30'h0, led_oe, led_pin}, 32'h2);
        rdc("cfg_rst", led_pkg::CFG_OFF, 32'h00000001);
        rdc("thr_rst", led_pkg::THR_OFF, 32'hffffffff);
        rdc("blink_rst", led_pkg::BLINK_OFF, 32'h003200fa);
        apb(1'b0, 12'h0fc, 32'h0, rv, ev);
        chk("unmapped_err", 32'(ev), 32'h1);
        $display("test reset done");
        // Pin table
        foreach (rows[i]) begin
            wr(led_pkg::CFG_OFF, rows[i].cfg);
            repeat (3) @(posedge pclk);
            chk("pin_oe", 32'(led_oe), 32'(rows[i].oe));
            chk("pin_level", 32'(led_pin), 32'(rows[i].pin));
            rdc("cfg_back", led_pkg::CFG_OFF, rows[i].rd);
        end
        $display("test pin table done");
        // Blink rates in test time base, then the 1 ms base
        wr(led_pkg::BLINK_OFF, 32'h00010003);
        wr(led_pkg::THR_OFF, 32'h0064000a);
        traffic_rate <= 16'd200;
        wr(led_pkg::CFG_OFF, 32'h8000000f);
        gap(gn);
        chk("sw_gap", 32'(gn), 32'd1000);
        wr(led_pkg::CFG_OFF, 32'h8000000d);
        gap(gn);
        chk("fast_gap", 32'(gn), 32'd500);
        traffic_rate <= 16'd100;
        gap(gn);
        chk("slow_gap", 32'(gn), 32'd1000);
        traffic_rate <= 16'd5;
        gap(gn);
        chk("steady_gap", 32'(gn), 32'd5000);
        chk("steady_pin", 32'(led_pin), 32'h1);
        wr(led_pkg::CFG_OFF, 32'h0000000f);
        gap(gn);
        chk("ms_base_gap", 32'(gn), 32'd5000);
        $display("test blink done");
        // Image load and link resets
        @(posedge pclk);
        ek <= 1'b1; el <= 1'b1; ee <= 1'b0; eeprom_load <= 1'b1;
        @(posedge pclk);
        eeprom_load <= 1'b0;
        rdc("cfg_image", led_pkg::CFG_OFF, 32'h0000000e);
        wr(led_pkg::CFG_OFF, 32'h80000003);
        @(posedge pclk);
        usb_reset <= 1'b1;
        @(posedge pclk);
        usb_reset <= 1'b0;
        rdc("cfg_usb", led_pkg::CFG_OFF, 32'h8000000e);
        wr(led_pkg::CFG_OFF, 32'h00000001);
        @(posedge pclk);
        reset_protect <= 1'b1; lite_reset <= 1'b1;
        @(posedge pclk);
        lite_reset <= 1'b0;
        rdc("cfg_protect", led_pkg::CFG_OFF, 32'h00000001);
        @(posedge pclk);
        reset_protect <= 1'b0; lite_reset <= 1'b1;
        @(posedge pclk);
        lite_reset <= 1'b0;
        rdc("cfg_lite", led_pkg::CFG_OFF, 32'h0000000c);
        repeat (3) @(posedge pclk);
        chk("pin_lite", {30'h0, led_oe, led_pin}, 32'h2);
        $display("test link reset done");
        // Mid-run reset, then link reset with no image loaded
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        chk("pin_rst2", {30'h0, led_oe, led_pin}, 32'h2);
        rdc("cfg_rst2", led_pkg::CFG_OFF, 32'h00000001);
        rdc("thr_rst2", led_pkg::THR_OFF, 32'hffffffff);
        wr(led_pkg::CFG_OFF, 32'h0000000c);
        @(posedge pclk);
        lite_reset <= 1'b1;
        @(posedge pclk);
        lite_reset <= 1'b0;
        rdc("cfg_default", led_pkg::CFG_OFF, 32'h00000001);
        // Lower byte lanes only reach the slow threshold
        pstrb <= 4'h3;
        wr(led_pkg::THR_OFF, 32'habcd0007);
        pstrb <= 4'hf;
        rdc("thr_strobe", led_pkg::THR_OFF, 32'hffff0007);
        $display("test mid reset done");
        stop_test();
    end
endmodule : tb_top
`default_nettype wire
